// ==== logic/oneshot_capture_compare_timer.sv ====
// One-shot and capture/compare 16-bit timer with request register
//
// What this block does
// - One-shot: count up on system clock until count equals reload.
// - At reload: interrupt, count to 0001H, clear enable, stop.
// - With output enabled, output pin inverts one cycle per one-shot reload.
// - Capture mode: after enable, wait for first selected input edge.
// - That first edge neither interrupts nor captures.
// - Later qualifying edges copy count into capture registers.
// - Capture event: interrupt, count to 0001H, keep counting.
// - Compare match without capture: interrupt, count to 0001H, continue.
// - Count advances once per prescale period of system clock.
// - Timer requests set request bits 5 and 6; bit 7 reads zero.
module oneshot_capture_compare_timer
  import timer_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic timer_in,
  input wire logic other_irq,
  output logic timer_out,
  output logic timer_out_oe,
  output logic irq
);
  logic [7:0] ctrl_reg;
  logic [15:0] cnt_reg;
  logic [15:0] rld_reg;
  logic [15:0] cap_reg;
  logic [7:0] irq_reg;
  logic [7:0] mask_reg;
  logic pulse_reg;
  tstate_t state_reg;
  logic en_prev_reg;
  logic tick;
  logic edge_hit;
  logic enabled;
  logic start;
  logic match;
  logic capture;
  logic reload_evt;
  logic timer_event;
  logic [7:0] set_bits;
  mode_t mode;

  assign enabled = ctrl_reg[CTRL_EN_BIT];
  assign mode = mode_t'(ctrl_reg[CTRL_MODE_BIT]);
  assign start = enabled && !en_prev_reg;

  ////////////////////////////////////////////////////////////////////////
  // Prescaler and input edge qualifier
  prescaler u_pre (
    .ref_clk(ref_clk),
    .rst(rst),
    .restart(start),
    .sel(ctrl_reg[CTRL_PRE_LSB +: CTRL_PRE_W]),
    .tick(tick)
  );

  edge_detect u_edge (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(timer_in),
    .falling(ctrl_reg[CTRL_POL_BIT]),
    .hit(edge_hit)
  );

  ////////////////////////////////////////////////////////////////////////
  // Event decode
  assign match = tick && (cnt_reg == rld_reg);
  assign capture = (state_reg == ST_RUN) && (mode == MODE_CAPCMP)
    && edge_hit;
  // Capture takes precedence over a compare match in the same cycle
  assign reload_evt = (state_reg == ST_RUN) && match && !capture;
  assign timer_event = capture || reload_evt;

  // Enable edge tracker
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      en_prev_reg <= 1'b0;
    end else begin
      en_prev_reg <= enabled;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter state machine
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (enabled) begin
            state_reg <= (mode == MODE_CAPCMP) ? ST_WAIT_EDGE : ST_RUN;
          end
        end
        ST_WAIT_EDGE: begin
          if (!enabled) begin
            state_reg <= ST_IDLE;
          end else if (edge_hit) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!enabled || (reload_evt && mode == MODE_ONESHOT)) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Count register: software write, restart at event, or advance on tick
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= CNT_RST;
    end else if (timer_event) begin
      cnt_reg <= CNT_RESTART;
    end else if (wr && addr == ADDR_CNT_HI) begin
      cnt_reg[15:8] <= wdata;
    end else if (wr && addr == ADDR_CNT_LO) begin
      cnt_reg[7:0] <= wdata;
    end else if (state_reg == ST_RUN && tick) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // Capture register holds the count at each later edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cap_reg <= CAP_RST;
    end else if (capture) begin
      cap_reg <= cnt_reg;
    end else if (wr && addr == ADDR_CAP_HI) begin
      cap_reg[15:8] <= wdata;
    end else if (wr && addr == ADDR_CAP_LO) begin
      cap_reg[7:0] <= wdata;
    end
  end

  // Reload / compare value
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rld_reg <= RLD_RST;
    end else if (wr && addr == ADDR_RLD_HI) begin
      rld_reg[15:8] <= wdata;
    end else if (wr && addr == ADDR_RLD_LO) begin
      rld_reg[7:0] <= wdata;
    end
  end

  // Control: one-shot timeout clears enable unless software writes too
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr && addr == ADDR_CTRL) begin
      ctrl_reg <= wdata;
    end else if (reload_evt && mode == MODE_ONESHOT) begin
      ctrl_reg[CTRL_EN_BIT] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output pin: polarity level, flipped for one cycle after a one-shot reload.
  // Polarity doubles as start level, so software can invert it later.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= reload_evt && mode == MODE_ONESHOT;
    end
  end

  assign timer_out = ctrl_reg[CTRL_POL_BIT] ^ pulse_reg;
  assign timer_out_oe = ctrl_reg[CTRL_OUTEN_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Request register: this block is timer 0; bit 6 from the sibling.
  // Set wins over a write-one-to-clear in the same cycle.
  always_comb begin
    set_bits = '0;
    set_bits[IRQ_T0_BIT] = timer_event;
    set_bits[IRQ_T1_BIT] = other_irq;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_reg <= IRQ_RST;
    end else if (wr && addr == ADDR_IRQ_REQ) begin
      irq_reg <= ((irq_reg & ~wdata) | set_bits) & IRQ_WRITABLE;
    end else begin
      irq_reg <= (irq_reg | set_bits) & IRQ_WRITABLE;
    end
  end

  // Mask register, same layout
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_reg <= IRQ_RST;
    end else if (wr && addr == ADDR_IRQ_MASK) begin
      mask_reg <= wdata & IRQ_WRITABLE;
    end
  end

  assign irq = |(irq_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////
  // Read port: data in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= READ_NONE;
    end else if (rd) begin
      case (addr)
        ADDR_CTRL: rdata <= ctrl_reg;
        ADDR_CNT_HI: rdata <= cnt_reg[15:8];
        ADDR_CNT_LO: rdata <= cnt_reg[7:0];
        ADDR_RLD_HI: rdata <= rld_reg[15:8];
        ADDR_RLD_LO: rdata <= rld_reg[7:0];
        ADDR_CAP_HI: rdata <= cap_reg[15:8];
        ADDR_CAP_LO: rdata <= cap_reg[7:0];
        ADDR_IRQ_MASK: rdata <= mask_reg;
        ADDR_IRQ_REQ: rdata <= irq_reg;
        default: rdata <= READ_NONE;
      endcase
    end else begin
      rdata <= READ_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // One-shot end: enable cleared, count reloaded, machine parked
  a_oneshot_stop: assert property (
    @(posedge ref_clk) disable iff (rst)
    reload_evt && mode == MODE_ONESHOT && !wr
    |=> !ctrl_reg[CTRL_EN_BIT] && cnt_reg == 16'h0001
    ##1 state_reg == ST_IDLE)
    else $error("one-shot did not stop with count 0001");

  // A stopped timer holds its count while software leaves it alone
  a_idle_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    state_reg == ST_IDLE && !wr |=> $stable(cnt_reg))
    else $error("count moved while stopped");

  // Output pin flips for exactly one cycle at a one-shot reload
  a_out_pulse: assert property (
    @(posedge ref_clk) disable iff (rst)
    reload_evt && mode == MODE_ONESHOT && !wr
    |=> timer_out != $past(timer_out) ##1 timer_out == $past(timer_out, 2))
    else $error("output pulse not exactly one cycle");

  // Outside a pulse the pin moves only with a control write
  a_out_steady: assert property (
    @(posedge ref_clk) disable iff (rst)
    !pulse_reg && !(reload_evt && mode == MODE_ONESHOT) && !wr
    |=> $stable(timer_out))
    else $error("output pin moved without a reload");

  // Capture mode sits still until the first selected edge, then runs
  a_wait_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    state_reg == ST_WAIT_EDGE && !wr |=> $stable(cnt_reg))
    else $error("count moved before first edge");
  a_wait_start: assert property (
    @(posedge ref_clk) disable iff (rst)
    state_reg == ST_WAIT_EDGE && enabled && edge_hit |=> state_reg == ST_RUN)
    else $error("first edge did not start the count");

  // The starting edge is silent: no capture, no request
  a_first_edge: assert property (
    @(posedge ref_clk) disable iff (rst)
    state_reg == ST_WAIT_EDGE && edge_hit && !wr
    |=> $stable(cap_reg)
    && irq_reg[IRQ_T0_BIT] == $past(irq_reg[IRQ_T0_BIT]))
    else $error("first edge captured or interrupted");

  // Later edges copy the count, request service and keep running
  a_capture_val: assert property (
    @(posedge ref_clk) disable iff (rst)
    capture |=> cap_reg == $past(cnt_reg) && cnt_reg == 16'h0001)
    else $error("capture value or restart wrong");
  a_cap_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    !capture && !wr |=> $stable(cap_reg))
    else $error("capture register moved without an edge");
  a_capture_runs: assert property (
    @(posedge ref_clk) disable iff (rst)
    capture && enabled && !wr
    |=> state_reg == ST_RUN && irq_reg[IRQ_T0_BIT])
    else $error("capture stopped counter or lost request");

  // Compare match in capture mode wraps and keeps counting
  a_compare_wrap: assert property (
    @(posedge ref_clk) disable iff (rst)
    reload_evt && mode == MODE_CAPCMP && enabled && !wr
    |=> cnt_reg == 16'h0001 && state_reg == ST_RUN)
    else $error("compare did not wrap to 0001");

  // Count steps once per tick; ticks are spaced by the divider
  a_count_step: assert property (
    @(posedge ref_clk) disable iff (rst)
    state_reg == ST_RUN && tick && !timer_event && !wr
    |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("count did not step on tick");
  a_prescale_gap: assert property (
    @(posedge ref_clk) disable iff (rst)
    tick && ctrl_reg[CTRL_PRE_LSB +: CTRL_PRE_W] != '0 && !wr
    |=> !tick)
    else $error("divided prescaler ticked twice in a row");

  // Request bits: set by events, sticky until cleared, bit 7 zero
  a_irq_set: assert property (
    @(posedge ref_clk) disable iff (rst)
    timer_event |=> irq_reg[IRQ_T0_BIT])
    else $error("timer event did not set its request");
  a_sibling_set: assert property (
    @(posedge ref_clk) disable iff (rst)
    other_irq |=> irq_reg[IRQ_T1_BIT])
    else $error("sibling request not stored");
  a_irq_sticky: assert property (
    @(posedge ref_clk) disable iff (rst)
    irq_reg[IRQ_T0_BIT]
    && !(wr && addr == ADDR_IRQ_REQ && wdata[IRQ_T0_BIT])
    |=> irq_reg[IRQ_T0_BIT])
    else $error("timer request dropped without a clear");
  a_irq_bit7: assert property (
    @(posedge ref_clk) disable iff (rst)
    !irq_reg[7])
    else $error("reserved request bit set");

  // Read data stand for one cycle only, so a stale byte is never seen
  a_read_idle: assert property (
    @(posedge ref_clk) disable iff (rst)
    !rd |=> rdata == READ_NONE)
    else $error("read data present without a read strobe");
endmodule

// ==== logic/timer_pkg.sv ====
// Constants shared by the one-shot / capture-compare timer
package timer_pkg;
  // Register indices (byte offsets in the timer's register space)
  localparam logic [11:0] ADDR_CTRL = 12'h0000;
  localparam logic [11:0] ADDR_CNT_HI = 12'h0001;
  localparam logic [11:0] ADDR_CNT_LO = 12'h0002;
  localparam logic [11:0] ADDR_RLD_HI = 12'h0003;
  localparam logic [11:0] ADDR_RLD_LO = 12'h0004;
  localparam logic [11:0] ADDR_CAP_HI = 12'h0005;
  localparam logic [11:0] ADDR_CAP_LO = 12'h0006;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h0007;
  localparam logic [11:0] ADDR_IRQ_REQ = 12'h0fc0;
  // Control register fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_POL_BIT = 6;
  localparam int CTRL_PRE_LSB = 3;
  localparam int CTRL_PRE_W = 3;
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_OUTEN_BIT = 1;
  // Interrupt request register fields
  localparam int IRQ_T0_BIT = 5;
  localparam int IRQ_T1_BIT = 6;
  localparam logic [7:0] IRQ_WRITABLE = 8'h007f;
  // Reset values, count restart value and idle read value
  localparam logic [7:0] CTRL_RST = 8'h0000;
  localparam logic [15:0] CNT_RST = 16'h0001;
  localparam logic [15:0] RLD_RST = 16'hffff;
  localparam logic [15:0] CAP_RST = 16'h0000;
  localparam logic [7:0] IRQ_RST = 8'h0000;
  localparam logic [15:0] CNT_RESTART = 16'h0001;
  localparam logic [7:0] READ_NONE = 8'h0000;
  // Modes
  typedef enum logic [0:0] {
    MODE_ONESHOT = 1'b0,
    MODE_CAPCMP = 1'b1
  } mode_t;
  // Counter states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT_EDGE = 2'b01,
    ST_RUN = 2'b10
  } tstate_t;
endpackage

// ==== logic/prescaler.sv ====
// Prescaler: one count-enable pulse every 2**sel system clocks
module prescaler
  import timer_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic [CTRL_PRE_W-1:0] sel,
  output logic tick
);
  logic [6:0] div_reg;
  logic [6:0] limit;

  // Divide value 1,2,4..128 per 3-bit select
  assign limit = 7'((8'h0001 << sel) - 8'h0001);

  ////////////////////////////////////////////////////////////////////////
  // Divider restarts on enable so the first period is always whole
  always_ff @(posedge ref_clk) begin
    if (rst || restart) begin
      div_reg <= '0;
    end else if (div_reg >= limit) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 7'h01;
    end
  end

  assign tick = !rst && !restart && (div_reg >= limit);

  // A select change may legally break the run of ticks, so both cycles
  // must still be at divide by one before a tick is demanded
  a_tick_period: assert property (
    @(posedge ref_clk) disable iff (rst)
    tick && sel == '0 ##1 sel == '0 && !restart |-> tick)
    else $error("prescaler by one did not tick every cycle");
endmodule

// ==== logic/edge_detect.sv ====
// Edge qualifier for the timer input pin
module edge_detect (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin_in,
  input wire logic falling,
  output logic hit
);
  logic last_reg;

  ////////////////////////////////////////////////////////////////////////
  // Input is synchronous; keep last level for edge compare.
  // Reset loads the pin level, so a pin idling high gives no false edge.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_reg <= pin_in;
    end else begin
      last_reg <= pin_in;
    end
  end

  // Polarity picks rising or falling edge
  assign hit = falling ? (last_reg && !pin_in) : (!last_reg && pin_in);
endmodule

// ==== dv/pin_model.sv ====
// Far-side pin model: timer input source and output pin watcher
module pin_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic toggle_req,
  input wire logic timer_out,
  input wire logic timer_out_oe,
  output logic timer_in,
  output logic [7:0] out_changes
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_out;
  //////////////////////////////////////////////////////////////////////
  // Input level moves only on request, so every edge is deliberate
  always_ff @(posedge ref_clk) begin
    if (rst)
      timer_in <= 1'b0;
    else if (toggle_req)
      timer_in <= ~timer_in;
  end
  // Count level changes only while the pin is driven; a pulse is two
  always_ff @(posedge ref_clk) begin
    last_out <= timer_out;
    if (rst)
      out_changes <= 8'h00;
    else if (timer_out_oe && timer_out !== last_out)
      out_changes <= out_changes + 8'h01;
  end
endmodule

// ==== dv/oneshot_capture_compare_timer_bench.sv ====
// Self-checking bench for the one-shot / capture-compare timer
module oneshot_capture_compare_timer_bench import timer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic other_irq = 1'b0;
  logic toggle_req = 1'b0;
  logic [7:0] rdata;
  logic timer_in, timer_out, timer_out_oe, irq;
  logic [7:0] out_changes;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int t_edge;
  localparam logic [11:0] RA[10] = '{12'h000, 12'h001, 12'h002, 12'h003,
    12'h004, 12'h005, 12'h006, 12'h007, 12'h020, 12'hfc0};
  localparam logic [7:0] RV[10] = '{8'h00, 8'h00, 8'h01, 8'hff, 8'hff,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  //////////////////////////////////////////////////////////////////////
  // Clock, cycle count and instances
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  oneshot_capture_compare_timer dut (.ref_clk(ref_clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .timer_in(timer_in), .other_irq(other_irq), .timer_out(timer_out),
    .timer_out_oe(timer_out_oe), .irq(irq));
  pin_model far (.ref_clk(ref_clk), .rst(rst), .toggle_req(toggle_req),
    .timer_out(timer_out), .timer_out_oe(timer_out_oe),
    .timer_in(timer_in), .out_changes(out_changes));
  //////////////////////////////////////////////////////////////////////
  // Verdict, comparison and bus tasks
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [11:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd_reg(a, v);
    chk8(v, exp);
  endtask
  // Bounded wait for the interrupt line; running out ends the run
  task automatic wait_irq(output int n);
    n = 0;
    #1;
    while (irq !== 1'b1 && n < 4000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (irq !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, irq, 1'b1);
      print_verdict();
    end
  endtask
  task automatic pin_edge();
    @(posedge ref_clk);
    toggle_req <= 1'b1;
    @(posedge ref_clk);
    toggle_req <= 1'b0;
    t_edge = cyc;
  endtask
  // Setup in the safe order: disabled, count, reload, mask, enable
  task automatic setup(input logic [7:0] ctl, input logic [15:0] rld);
    wr_reg(ADDR_CTRL, ctl & 8'h7f);
    wr_reg(ADDR_CNT_HI, 8'h00);
    wr_reg(ADDR_CNT_LO, 8'h01);
    wr_reg(ADDR_RLD_HI, rld[15:8]);
    wr_reg(ADDR_RLD_LO, rld[7:0]);
    wr_reg(ADDR_IRQ_MASK, 8'h20);
    wr_reg(ADDR_IRQ_REQ, 8'hff);
    wr_reg(ADDR_CTRL, ctl);
  endtask
  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int n3, n5, t0;
    logic [7:0] v;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (RA[i]) rd_chk(RA[i], RV[i]);
    $display("reset value test done");
    setup(8'h82, 16'h0003);
    wait_irq(n3);
    repeat (3) @(posedge ref_clk);
    #1;
    chk8(out_changes, 8'h02);
    chk8({7'b0, timer_out}, 8'h00);
    chk8({7'b0, timer_out_oe}, 8'h01);
    rd_chk(ADDR_CTRL, 8'h02);
    rd_chk(ADDR_CNT_LO, 8'h01);
    rd_chk(ADDR_IRQ_REQ, 8'h20);
    wr_reg(ADDR_IRQ_REQ, 8'ha0);
    #1 chk8({7'b0, irq}, 8'h00);
    rd_chk(ADDR_IRQ_REQ, 8'h00);
    $display("one-shot test done");
    // Prescale 4: two more reload steps cost exactly eight cycles
    setup(8'h92, 16'h0003);
    wait_irq(n3);
    setup(8'h92, 16'h0005);
    wait_irq(n5);
    chk8(8'(n5 - n3), 8'h08);
    // Preset level, start, then invert for a lasting change
    setup(8'h82, 16'h0010);
    wr_reg(ADDR_CTRL, 8'hc2);
    wait_irq(n3);
    repeat (3) @(posedge ref_clk);
    chk8({7'b0, timer_out}, 8'h01);
    $display("prescale and level test done");
    // Sibling request is stored but masked until bit 6 is unmasked
    wr_reg(ADDR_IRQ_REQ, 8'hff);
    other_irq <= 1'b1;
    @(posedge ref_clk);
    other_irq <= 1'b0;
    rd_chk(ADDR_IRQ_REQ, 8'h40);
    chk8({7'b0, irq}, 8'h00);
    wr_reg(ADDR_IRQ_MASK, 8'h40);
    #1 chk8({7'b0, irq}, 8'h01);
    $display("mask test done");
    // Capture: idle until first rising edge, which stays silent
    setup(8'h81, 16'hffff);
    repeat (6) @(posedge ref_clk);
    rd_chk(ADDR_CNT_LO, 8'h01);
    pin_edge();
    t0 = t_edge;
    repeat (5) @(posedge ref_clk);
    rd_chk(ADDR_IRQ_REQ, 8'h00);
    rd_chk(ADDR_CAP_LO, 8'h00);
    pin_edge();
    repeat (10) @(posedge ref_clk);
    pin_edge();
    wait_irq(n3);
    rd_reg(ADDR_CAP_LO, v);
    n5 = t_edge - t0;
    chk8({7'b0, v >= 8'(n5) && v <= 8'(n5 + 2)}, 8'h01);
    rd_chk(ADDR_CAP_HI, 8'h00);
    rd_chk(ADDR_CTRL, 8'h81);
    rd_chk(ADDR_CNT_HI, 8'h00);
    $display("capture test done");
    // Compare match on falling-edge start, no capture taken
    setup(8'hc1, 16'h0008);
    pin_edge();
    wait_irq(n3);
    rd_chk(ADDR_CTRL, 8'hc1);
    rd_chk(ADDR_CAP_LO, v);
    rd_chk(ADDR_IRQ_REQ, 8'h20);
    $display("compare test done");
    print_verdict();
  end
endmodule
